/* File: design/ddri_seq.sv */
/*
 * DRAM-side reset, initialisation, mode register and access model.
 * Assumes clk is the command clock and the controller keeps its own
 * timing and ordering obligations; reset_pin_n arrives unsynchronised.
 */
// Summary of operation
// - bursts run eight beats or chopped four, reads from start column, writes from 0 or 4, programmed order.
// - activate takes bank from three bank bits, row from A0 to A14.
// - read or write: read column starts burst, write starts at 0 or chopped at 4, A10 auto precharge, A12 low chops when enabled.
// - eightfold prefetch: one core word per access, two pin beats per clock.
// - after reset release, 500 us internal init before clock enable rises.
// - termination off during reset and until clock enable first registers high.
// - four mode registers, undefined defaults, all rewritten after each reset.
// - mode writes and dll reset leave the array unchanged.
`timescale 1ns/1ps
`include "ddri_regs.svh"

module ddri_seq #(
    parameter int INIT_CYC = `DDRI_INIT_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    reset_pin_n,
    input  wire logic                    cke,
    input  wire logic                    odt,
    input  ddri_pkg::ddri_cmd_t          cmd,
    output logic                         init_busy_r,
    output logic                         term_en_r,
    output logic                         act_pulse_r,
    output logic [`DDRI_BANK_W-1:0]      act_bank_r,
    output logic [`DDRI_ROW_W-1:0]       act_row_r,
    output logic                         burst_valid_r,
    output logic                         burst_write_r,
    output logic                         burst_chop_r,
    output logic                         auto_pre_r,
    output logic                         core_xfer_r,
    output logic [9:0]                   col_base_r,
    output logic [2:0]                   beat_even_r,
    output logic [2:0]                   beat_odd_r,
    output logic                         dll_reset_r,
    output logic                         zq_long_r,
    output ddri_pkg::ddri_mr_t           mr_r,
    output logic                         mr_all_wr_r
);
    import ddri_pkg::*;

    // reset pin synchroniser; the first stage feeds only the second
    logic        rp_s1_r;
    logic        rp_s2_r;
    logic        rp_s3_r;
    logic        rp_q_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rp_s1_r <= 1'b0;
            rp_s2_r <= 1'b0;
            rp_s3_r <= 1'b0;
            rp_q_r  <= 1'b0;
        end else begin
            rp_s1_r <= reset_pin_n;
            rp_s2_r <= rp_s1_r;
            rp_s3_r <= rp_s2_r;
            if (rp_s2_r == rp_s3_r) begin
                rp_q_r <= rp_s3_r;
            end
        end
    end

    // command decode, only while clock enable is high in run state
    ddri_state_t state_r;
    ddri_state_t state_nxt;
    logic [13:0] init_cnt_r;
    logic [13:0] init_cnt_nxt;
    logic        live;
    logic [2:0]  code;
    logic        is_mrs;
    logic        is_act;
    logic        is_rd;
    logic        is_wr;
    logic        is_zql;

    assign live   = (state_r == ST_RUN) && cke && !cmd.cs_n;
    assign code   = {cmd.ras_n, cmd.cas_n, cmd.we_n};
    assign is_mrs = live && (code == `DDRI_CMD_MRS);
    assign is_act = live && (code == `DDRI_CMD_ACT);
    assign is_rd  = live && (code == `DDRI_CMD_RD);
    assign is_wr  = live && (code == `DDRI_CMD_WR);
    assign is_zql = live && (code == `DDRI_CMD_ZQ) && cmd.addr[`DDRI_AP_BIT];

    // internal init runs on its own count, needing no command activity
    always_comb begin
        state_nxt    = state_r;
        init_cnt_nxt = init_cnt_r;
        if (!rp_q_r) begin
            state_nxt    = ST_HOLD;
            init_cnt_nxt = '0;
        end else begin
            unique case (state_r)
                ST_HOLD: begin
                    state_nxt    = ST_INIT;
                    init_cnt_nxt = '0;
                end
                ST_INIT: begin
                    if (init_cnt_r == 14'(INIT_CYC - 1)) begin
                        state_nxt = ST_WCKE;
                    end else begin
                        init_cnt_nxt = init_cnt_r + 14'h1;
                    end
                end
                ST_WCKE: begin
                    if (cke) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: state_nxt = ST_RUN;
                default: state_nxt = ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r    <= ST_HOLD;
            init_cnt_r <= '0;
        end else begin
            state_r    <= state_nxt;
            init_cnt_r <= init_cnt_nxt;
        end
    end

    ddri_mode_bank u_mode (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clr      (!rp_q_r),
        .wr       (is_mrs),
        .sel      (cmd.ba[1:0]),
        .wdata    (cmd.addr),
        .mr_r     (mr_r),
        .all_wr_r (mr_all_wr_r)
    );

    // column order inside a burst: xor for interleave, wrap-add for sequential
    function automatic logic [2:0] col_of(input logic [2:0] s, input logic [2:0] i,
                                          input logic il);
        col_of = il ? (s ^ i) : {s[2] ^ i[2], s[1:0] + i[1:0]};
    endfunction

    logic       bst_start;
    logic       chop_cmd;
    logic [2:0] start_cmd;
    logic [1:0] bl_mode;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic [2:0] start_r;
    logic [2:0] start_nxt;
    logic       il_r;
    logic       il_nxt;
    logic       valid_nxt;
    logic       wr_nxt;
    logic       chop_nxt;
    logic       ap_nxt;
    logic [9:0] base_nxt;

    assign bl_mode   = mr_r[0][`DDRI_MR0_BL_LSB +: 2];
    // a new read or write is taken only once the previous burst has ended
    assign bst_start = (is_rd || is_wr) && !burst_valid_r;
    assign chop_cmd  = (bl_mode == `DDRI_BL_FIXED4) ||
                       ((bl_mode == `DDRI_BL_OTF) && !cmd.addr[`DDRI_BC_BIT]);
    // writes ignore low start bits: chopped writes keep only bit two
    assign start_cmd = is_wr ? {chop_cmd & cmd.addr[2], 2'b00} : cmd.addr[2:0];

    always_comb begin
        cnt_nxt   = cnt_r;
        start_nxt = start_r;
        il_nxt    = il_r;
        valid_nxt = 1'b0;
        wr_nxt    = burst_write_r;
        chop_nxt  = burst_chop_r;
        ap_nxt    = auto_pre_r;
        base_nxt  = col_base_r;
        if (bst_start) begin
            valid_nxt = 1'b1;
            cnt_nxt   = 2'h0;
            start_nxt = start_cmd;
            il_nxt    = mr_r[0][`DDRI_MR0_BT_BIT];
            wr_nxt    = is_wr;
            chop_nxt  = chop_cmd;
            ap_nxt    = cmd.addr[`DDRI_AP_BIT];
            base_nxt  = {cmd.addr[11], cmd.addr[9:3], 2'b00};
        end else if (burst_valid_r && (cnt_r != (burst_chop_r ? 2'h1 : 2'h3))) begin
            valid_nxt = 1'b1;
            cnt_nxt   = cnt_r + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !rp_q_r) begin
            cnt_r         <= '0;
            start_r       <= '0;
            il_r          <= 1'b0;
            burst_valid_r <= 1'b0;
            burst_write_r <= 1'b0;
            burst_chop_r  <= 1'b0;
            auto_pre_r    <= 1'b0;
            col_base_r    <= '0;
            beat_even_r   <= '0;
            beat_odd_r    <= '0;
            core_xfer_r   <= 1'b0;
        end else begin
            cnt_r         <= cnt_nxt;
            start_r       <= start_nxt;
            il_r          <= il_nxt;
            burst_valid_r <= valid_nxt;
            burst_write_r <= wr_nxt;
            burst_chop_r  <= chop_nxt;
            auto_pre_r    <= ap_nxt;
            col_base_r    <= base_nxt;
            // two pin beats per clock
            beat_even_r   <= col_of(start_nxt, {cnt_nxt, 1'b0}, il_nxt);
            beat_odd_r    <= col_of(start_nxt, {cnt_nxt, 1'b1}, il_nxt);
            // one 8n-bit core word per access
            core_xfer_r   <= bst_start;
        end
    end

    // activate, termination and pulses
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            init_busy_r <= 1'b1;
            term_en_r   <= 1'b0;
            act_pulse_r <= 1'b0;
            act_bank_r  <= '0;
            act_row_r   <= '0;
            dll_reset_r <= 1'b0;
            zq_long_r   <= 1'b0;
        end else begin
            init_busy_r <= (state_nxt != ST_RUN);
            // termination stays high-impedance until cke registers high
            term_en_r   <= (state_nxt == ST_RUN) && odt;
            act_pulse_r <= is_act;
            if (is_act) begin
                act_bank_r <= cmd.ba;
                act_row_r  <= cmd.addr;
            end
            // mode writes touch only the mode bank and the dll reset pulse, never the array
            dll_reset_r <= is_mrs && (cmd.ba[1:0] == 2'h0) &&
                           cmd.addr[`DDRI_MR0_DLLRST_BIT];
            zq_long_r   <= is_zql;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_term_off_reset: assert property (!rp_q_r |=> !term_en_r ##1 !term_en_r)
        else $error("termination enabled during reset");
    a_term_wait_cke: assert property ((state_r == ST_WCKE && !cke) |=> !term_en_r)
        else $error("termination enabled before cke registered");
    a_init_full_wait: assert property (
        (state_r == ST_WCKE && $past(state_r) != ST_WCKE) |->
        ($past(state_r) == ST_INIT && $past(init_cnt_r) == 14'(INIT_CYC - 1)))
        else $error("internal init left before full count");
    a_act_bank_row: assert property (is_act |=>
        act_pulse_r && act_bank_r == $past(cmd.ba) && act_row_r == $past(cmd.addr))
        else $error("activate bank or row not captured");
    a_burst_eight: assert property (disable iff (sys_rst || !rp_q_r)
        (bst_start && !chop_cmd) |=> burst_valid_r[*4] ##1 !burst_valid_r)
        else $error("full burst not four clocks long");
    a_burst_chop: assert property (disable iff (sys_rst || !rp_q_r)
        (bst_start && chop_cmd) |=> burst_valid_r[*2] ##1 !burst_valid_r)
        else $error("chopped burst not two clocks long");
    a_first_beat_col: assert property ((bst_start && is_rd && rp_q_r) |=>
        beat_even_r == $past(cmd.addr[2:0]))
        else $error("read burst does not start at selected column");
    a_ap_chop_flags: assert property ((bst_start && rp_q_r) |=>
        auto_pre_r == $past(cmd.addr[10]) && burst_chop_r == $past(chop_cmd))
        else $error("auto precharge or chop flag wrong");
    a_core_once: assert property ((bst_start && rp_q_r) |=>
        core_xfer_r ##1 !core_xfer_r)
        else $error("core transfer not a single pulse per access");
    a_mrs_no_array: assert property ((is_mrs && !burst_valid_r) |=>
        !burst_valid_r && $stable(act_row_r))
        else $error("mode write disturbed array activity");

endmodule : ddri_seq

/* File: design/ddri_regs.svh */
/*
 * Constants of the DRAM-side init and mode programming block: timing counts,
 * mode register field positions and command pin codes.
 * Assumes inclusion by bare name from the block's package and modules.
 */
`ifndef DDRI_REGS_SVH
`define DDRI_REGS_SVH

// clock rate and internal initialisation time
`define DDRI_CLK_KHZ        20000
`define DDRI_T_INIT_US      500
`define DDRI_INIT_CYC       ((`DDRI_T_INIT_US * `DDRI_CLK_KHZ + 999) / 1000)

// widths
`define DDRI_ROW_W          15
`define DDRI_BANK_W         3
`define DDRI_MR_NUM         4

// mode register fields
`define DDRI_MR0_BL_LSB     0
`define DDRI_MR0_BT_BIT     3
`define DDRI_MR0_DLLRST_BIT 8
`define DDRI_BL_FIXED8      2'h0
`define DDRI_BL_OTF         2'h1
`define DDRI_BL_FIXED4      2'h2

// address bits with meaning on read and write
`define DDRI_AP_BIT         10
`define DDRI_BC_BIT         12

// command pin codes {ras_n, cas_n, we_n}
`define DDRI_CMD_MRS        3'h0
`define DDRI_CMD_ACT        3'h3
`define DDRI_CMD_WR         3'h4
`define DDRI_CMD_RD         3'h5
`define DDRI_CMD_ZQ         3'h6

`endif

/* File: design/ddri_pkg.sv */
/*
 * Types of the DRAM-side init and mode programming block.
 * Assumes ddri_regs.svh is on the include path.
 */
`include "ddri_regs.svh"

package ddri_pkg;

    typedef struct packed {
        logic                    cs_n;
        logic                    ras_n;
        logic                    cas_n;
        logic                    we_n;
        logic [`DDRI_BANK_W-1:0] ba;
        logic [`DDRI_ROW_W-1:0]  addr;
    } ddri_cmd_t;

    typedef enum logic [3:0] {
        ST_HOLD = 4'h1,
        ST_INIT = 4'h2,
        ST_WCKE = 4'h4,
        ST_RUN  = 4'h8
    } ddri_state_t;

    typedef logic [`DDRI_MR_NUM-1:0][`DDRI_ROW_W-1:0] ddri_mr_t;

endpackage : ddri_pkg

/* File: design/ddri_mode_bank.sv */
/*
 * Four mode registers with written flags; outputs come from registers.
 * Assumes writes arrive as single-cycle strobes on the same clock.
 */
`timescale 1ns/1ps
`include "ddri_regs.svh"

module ddri_mode_bank (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    clr,
    input  wire logic                    wr,
    input  wire logic [1:0]              sel,
    input  wire logic [`DDRI_ROW_W-1:0]  wdata,
    output ddri_pkg::ddri_mr_t           mr_r,
    output logic                         all_wr_r
);
    import ddri_pkg::*;

    ddri_mr_t                mr_nxt;
    logic [`DDRI_MR_NUM-1:0] wrt_r;
    logic [`DDRI_MR_NUM-1:0] wrt_nxt;

    always_comb begin
        mr_nxt  = mr_r;
        wrt_nxt = wrt_r;
        if (clr) begin
            wrt_nxt = '0;
        end else if (wr) begin
            mr_nxt[sel] = wdata;
            // dll reset is self-clearing once issued
            if (sel == 2'h0) begin
                mr_nxt[0][`DDRI_MR0_DLLRST_BIT] = 1'b0;
            end
            wrt_nxt[sel] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mr_r     <= '0;
            wrt_r    <= '0;
            all_wr_r <= 1'b0;
        end else begin
            mr_r     <= mr_nxt;
            wrt_r    <= wrt_nxt;
            all_wr_r <= &wrt_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_clr_drops_all: assert property (clr |=> !all_wr_r)
        else $error("mode registers still marked written after reset");
    a_all_needs_four: assert property (
        (!all_wr_r && !wr) |=> !all_wr_r)
        else $error("all-written flag rose without a mode register write");

endmodule : ddri_mode_bank

/* File: bench/ddri_ctrl_model.sv */
/*
 * Controller-side model: drives reset pin, clock enable, termination, commands.
 * Assumes clk comes from the bench; its tasks are called hierarchically.
 */
`timescale 1ns/1ps
`include "ddri_regs.svh"

module ddri_ctrl_model #(
    parameter int INIT_WAIT = 30,
    parameter int XPR       = 5,
    parameter int MRD       = 4,
    parameter int ZQ_WAIT   = 40
) (
    input  wire logic           clk,
    output logic                reset_pin_n,
    output logic                cke,
    output logic                odt,
    output ddri_pkg::ddri_cmd_t cmd
);
    import ddri_pkg::*;

    initial begin
        reset_pin_n = 1'b0;
        cke         = 1'b0;
        odt         = 1'b1; // static for the whole run
        cmd         = {1'b1, 21'h0};
    end

    function automatic ddri_cmd_t mk(input logic [2:0] op, input logic [2:0] ba,
                                     input logic [14:0] a);
        return {1'b0, op, ba, a};
    endfunction : mk

    task automatic issue(input ddri_cmd_t c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        // nop with flipped address so a stale value never looks valid
        cmd <= mk(3'h7, ~c.ba, ~c.addr);
    endtask : issue

    task automatic mrs(input logic [2:0] ba, input logic [14:0] v);
        issue(mk(`DDRI_CMD_MRS, ba, v)); // whole register each time
        repeat (MRD - 1) @(posedge clk);
    endtask : mrs

    task automatic reset_seq(input int hold);
        @(posedge clk);
        cke         <= 1'b0;
        reset_pin_n <= 1'b0;
        repeat (hold) @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (INIT_WAIT) @(posedge clk); // clock already running
        cmd <= mk(3'h7, 3'h0, 15'h0);
        @(posedge clk);
    endtask : reset_seq

    task automatic init_seq(input logic [14:0] m0, m1, m2, m3);
        @(posedge clk);
        cke <= 1'b1; // held high until the next reset_seq drops it
        repeat (XPR) @(posedge clk);
        mrs(3'h2, m2);
        mrs(3'h3, m3);
        mrs(3'h1, {m1[14:1], 1'b0});
        mrs(3'h0, m0 | 15'h0100);
        issue(mk(`DDRI_CMD_ZQ, 3'h0, 15'h0400));
        repeat (ZQ_WAIT) @(posedge clk);
    endtask : init_seq
endmodule : ddri_ctrl_model

/* File: bench/test_ddri_seq.sv */
/*
 * Self-checking bench for ddri_seq with the controller model on its far side.
 * Assumes the design files and ddri_regs.svh are compiled first.
 */
`timescale 1ns/1ps
`include "ddri_regs.svh"

module test_ddri_seq;
    import ddri_pkg::*;

    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        reset_pin_n, cke, odt, init_busy_r, term_en_r, act_pulse_r;
    logic        burst_valid_r, burst_write_r, burst_chop_r, auto_pre_r;
    logic        core_xfer_r, dll_reset_r, zq_long_r, mr_all_wr_r;
    logic [2:0]  act_bank_r, beat_even_r, beat_odd_r;
    logic [14:0] act_row_r;
    logic [9:0]  col_base_r;
    ddri_cmd_t   cmd;
    ddri_mr_t    mr_r;
    int          fails, num_checks, cyc, bv_n, cx_n, dll_n, zq_n, term_n, act_n;

    ddri_seq #(.INIT_CYC(20)) dut (
        .clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n), .cke(cke),
        .odt(odt), .cmd(cmd), .init_busy_r(init_busy_r), .term_en_r(term_en_r),
        .act_pulse_r(act_pulse_r), .act_bank_r(act_bank_r), .act_row_r(act_row_r),
        .burst_valid_r(burst_valid_r), .burst_write_r(burst_write_r),
        .burst_chop_r(burst_chop_r), .auto_pre_r(auto_pre_r),
        .core_xfer_r(core_xfer_r), .col_base_r(col_base_r),
        .beat_even_r(beat_even_r), .beat_odd_r(beat_odd_r),
        .dll_reset_r(dll_reset_r), .zq_long_r(zq_long_r), .mr_r(mr_r),
        .mr_all_wr_r(mr_all_wr_r)
    );

    ddri_ctrl_model ctl (
        .clk(clk), .reset_pin_n(reset_pin_n), .cke(cke), .odt(odt), .cmd(cmd)
    );

    always #25 clk = ~clk;

    task automatic final_report();
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // pulse and level counters, sampled once per cycle
    always @(posedge clk) begin
        cyc++;
        bv_n   += int'(burst_valid_r === 1'b1);
        cx_n   += int'(core_xfer_r === 1'b1);
        dll_n  += int'(dll_reset_r === 1'b1);
        zq_n   += int'(zq_long_r === 1'b1);
        act_n  += int'(act_pulse_r === 1'b1);
        term_n += int'(term_en_r === 1'b1 && init_busy_r === 1'b1);
        if (cyc == 6000) begin
            fails++;
            final_report();
        end
    end

    function automatic logic [2:0] order(input logic [2:0] s, input logic [2:0] i,
                                         input logic il);
        return il ? (s ^ i) : {s[2] ^ i[2], s[1:0] + i[1:0]};
    endfunction : order

    task automatic t_init(input int hold);
        term_n = 0;
        ctl.reset_seq(hold);
        @(negedge clk);
        check("busy", init_busy_r, 1'b1);
        check("term_wait", term_en_r, 1'b0);
        check("term_off", term_n, 0);
        check("allwr", mr_all_wr_r, 1'b0);
        dll_n = 0;
        zq_n  = 0;
        ctl.init_seq(15'h0521, 15'h0047, 15'h0018, 15'h0004);
        @(negedge clk);
        check("busy", init_busy_r, 1'b0);
        check("term_on", term_en_r, 1'b1);
        check("mr0", mr_r[0], 15'h0421);
        check("mr1", mr_r[1], 15'h0046);
        check("mr2", mr_r[2], 15'h0018);
        check("mr3", mr_r[3], 15'h0004);
        check("allwr", mr_all_wr_r, 1'b1);
        check("dll", dll_n, 1);
        check("zq", zq_n, 1);
    endtask : t_init

    task automatic t_act(input logic [2:0] b, input logic [14:0] r);
        act_n = 0;
        ctl.issue(ctl.mk(`DDRI_CMD_ACT, b, r));
        repeat (3) @(negedge clk);
        check("act", act_n, 1);
        check("bank", act_bank_r, b);
        check("row", act_row_r, r);
    endtask : t_act

    task automatic t_burst(input logic wr, input logic [14:0] a, input logic il,
                           input logic chop);
        logic [2:0] s;
        int         k;
        s = wr ? {chop & a[2], 2'b00} : a[2:0];
        ctl.issue(ctl.mk(wr ? `DDRI_CMD_WR : `DDRI_CMD_RD, 3'h5, a));
        k = 0;
        @(negedge clk);
        while (burst_valid_r !== 1'b1 && k < 3) begin
            @(negedge clk);
            k++;
        end
        check("write", burst_write_r, wr);
        check("chop", burst_chop_r, chop);
        check("autopre", auto_pre_r, a[10]);
        check("colbase", col_base_r, {a[11], a[9:3], 2'b00});
        for (k = 0; k < (chop ? 4 : 8); k += 2) begin
            check("valid", burst_valid_r, 1'b1);
            check("core", core_xfer_r, k == 0);
            check("even", beat_even_r, order(s, k[2:0], il));
            check("odd", beat_odd_r, order(s, k[2:0] + 3'h1, il));
            @(negedge clk);
        end
        check("done", burst_valid_r, 1'b0);
    endtask : t_burst

    task automatic t_mode(input logic [14:0] v);
        ctl.issue(ctl.mk(3'h2, 3'h0, 15'h0400)); // precharge all banks first
        ctl.mrs(3'h0, v);
        @(negedge clk);
        check("mr0", mr_r[0], v);
        check("dll", dll_n, 1);
        check("row", act_row_r, 15'h7fff);
    endtask : t_mode

    // a read landing mid-burst must be dropped without a trace
    task automatic t_refuse();
        bv_n = 0;
        cx_n = 0;
        ctl.issue(ctl.mk(`DDRI_CMD_RD, 3'h5, 15'h0000));
        ctl.issue(ctl.mk(`DDRI_CMD_RD, 3'h5, 15'h0004));
        repeat (8) @(negedge clk);
        check("bvcnt", bv_n, 4);
        check("xfer", cx_n, 1);
    endtask : t_refuse

    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        check("busy", init_busy_r, 1'b1);
        t_init(4000);
        t_act(3'h5, 15'h5a3c);
        t_act(3'h7, 15'h7fff);
        t_burst(1'b0, 15'h1a05, 1'b0, 1'b0);
        t_burst(1'b0, 15'h0403, 1'b0, 1'b1);
        t_burst(1'b1, 15'h1407, 1'b0, 1'b0);
        t_burst(1'b1, 15'h0006, 1'b0, 1'b1);
        t_mode(15'h0429);
        t_burst(1'b0, 15'h1005, 1'b1, 1'b0);
        t_burst(1'b0, 15'h0007, 1'b1, 1'b1);
        t_mode(15'h0402);
        t_burst(1'b0, 15'h1001, 1'b0, 1'b1);
        t_mode(15'h0400);
        t_burst(1'b0, 15'h0002, 1'b0, 1'b0);
        t_refuse();
        t_init(2);
        final_report();
    end
endmodule : test_ddri_seq
